// ---- pio_map.vh ----
// Register map, field layout and encodings of the parallel pattern I/O mode control
// What this block does
// - Wide input: second port extends first
// - Wide output: first port extends second
// - Split: first in, second out, 8/16
// - Each port terminator switched independently
// - Six control lines, own edge polarity
// - Input pace: counter 0, 20 or 10 MHz
// - Strobe mode: sample each active request edge
// - Input request/acknowledge handshake mode
// - Input starts immediately or on trigger
// - Output pace: counter 1, fixed, or handshake
// - Burst output paced, honours acknowledge line
// - Output starts immediately or on trigger
// - Output waits until not almost empty
// - Output waits for trigger and level
// - Programmable almost-empty threshold for output FIFO
// - Up to four words after acknowledge drops
// - Latch on request, acknowledge when ready
// - Present word, request, wait acknowledge, repeat
// - Strobe mode acknowledge: enabled, not almost full
`ifndef PIO_MAP_VH
`define PIO_MAP_VH
// Register byte offsets
`define REG_CONFIG     8'h00
`define REG_POLARITY   8'h04
`define REG_IN_MODE    8'h08
`define REG_OUT_MODE   8'h0C
`define REG_THRESH     8'h10
`define REG_CONTROL    8'h14
`define REG_STATUS     8'h18
`define REG_IN_COUNT   8'h1C
`define REG_OUT_COUNT  8'h20
// Port configurations
`define CFG_WIDE_IN    3'h0
`define CFG_WIDE_OUT   3'h1
`define CFG_NN         3'h2
`define CFG_NW         3'h3
`define CFG_WN         3'h4
`define CFG_WW         3'h5
`define CFG_RESET      3'h5
// Polarity bit positions
`define POL_IN_REQ     0
`define POL_IN_ACK     1
`define POL_IN_TRIG    2
`define POL_OUT_REQ    3
`define POL_OUT_ACK    4
`define POL_OUT_TRIG   5
// Input pacing modes
`define IN_PACE_CNT    3'h0
`define IN_PACE_FAST   3'h1
`define IN_PACE_SLOW   3'h2
`define IN_PACE_STROBE 3'h3
`define IN_PACE_HS     3'h4
// Output pacing modes
`define OUT_PACE_CNT   3'h0
`define OUT_PACE_FAST  3'h1
`define OUT_PACE_SLOW  3'h2
`define OUT_PACE_HS    3'h3
`define OUT_BURST_CNT  3'h4
`define OUT_BURST_SLOW 3'h5
`define OUT_BURST_FAST 3'h6
// Output start modes
`define OUT_START_NOW  2'h0
`define OUT_START_TRIG 2'h1
`define OUT_START_FIFO 2'h2
`define OUT_START_BOTH 2'h3
// Pace source selects
`define SRC_CNT        2'h0
`define SRC_FAST       2'h1
`define SRC_SLOW       2'h2
// Words allowed after acknowledge drops
`define BURST_EXTRA    3'h4
// Reset value of the almost-empty threshold
`define THRESH_RESET   16'h0010
`endif

// ---- pin_sync.v ----
// Three-stage pin synchroniser with polarity inversion and rise detect
`timescale 1ns/1ns
module pin_sync (
   input  wire pclk,
   input  wire presetn,
   input  wire pin,
   input  wire invert,
   output reg  level,
   output wire rise
);
   reg s1_r; // First stage, read by s2 only
   reg s2_r; // Second stage
   reg s3_r; // Third stage
   reg lvl_q; // Previous active-high level

   // Sync chain; level moves once stages two and three agree
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_r  <= 1'b0;
         s2_r  <= 1'b0;
         s3_r  <= 1'b0;
         level <= 1'b0;
         lvl_q <= 1'b0;
      end else begin
         s1_r  <= pin;
         s2_r  <= s1_r;
         s3_r  <= s2_r;
         if (s2_r == s3_r) begin
            level <= s3_r ^ invert;
         end
         lvl_q <= level;
      end
   end

   // Active edge after inversion
   assign rise = level & ~lvl_q;
endmodule // pin_sync

// ---- pace_select.v ----
// Pacing tick selector: counter tick, every clock, or every second clock
`timescale 1ns/1ns
`include "pio_map.vh"
module pace_select (
   input  wire       pclk,
   input  wire       presetn,
   input  wire [1:0] src,
   input  wire       counter_tick,
   output reg        tick
);
   reg half_r; // Divide-by-two phase

   // Half-rate phase toggles every clock
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         half_r <= 1'b0;
      end else begin
         half_r <= ~half_r;
      end
   end

   // Pick the pacing source
   always @* begin
      case (src)
         `SRC_CNT:  tick = counter_tick;
         `SRC_FAST: tick = 1'b1;
         `SRC_SLOW: tick = half_r;
         default:   tick = 1'b0;
      endcase
   end
endmodule // pace_select

// ---- pio_mode_ctrl.v ----
// Mode, pacing and handshake control of the 32-bit parallel pattern I/O engine
`timescale 1ns/1ns
`include "pio_map.vh"
module pio_mode_ctrl #(
   parameter DW = 32,
   parameter LW = 16
) (
   input  wire          pclk,
   input  wire          presetn,
   input  wire          psel,
   input  wire          penable,
   input  wire          pwrite,
   input  wire [7:0]    paddr,
   input  wire [31:0]   pwdata,
   output reg  [31:0]   prdata,
   output wire          pready,
   output wire          pslverr,
   input  wire [15:0]   first_port_in,
   output wire [15:0]   first_port_out,
   output wire          first_port_oe,
   input  wire [15:0]   second_port_in,
   output wire [15:0]   second_port_out,
   output wire          second_port_oe,
   output wire          first_term_en,
   output wire          second_term_en,
   input  wire          in_request_line,
   output wire          in_acknowledge_line,
   input  wire          in_trigger_line,
   output wire          out_request_line,
   input  wire          out_acknowledge_line,
   input  wire          out_trigger_line,
   input  wire          counter0_tick,
   input  wire          counter1_tick,
   output reg  [DW-1:0] in_word,
   output reg           in_word_valid,
   input  wire          in_fifo_almost_full,
   input  wire [DW-1:0] out_word,
   input  wire          out_word_avail,
   input  wire [LW-1:0] out_fifo_level,
   output wire          out_word_take
);
   // Direction states
   localparam ST_IDLE = 2'h0;
   localparam ST_ARM  = 2'h1;
   localparam ST_RUN  = 2'h2;
   localparam ST_WACK = 2'h3;

   reg  [2:0]    cfg_r;       // Port configuration
   reg  [1:0]    term_r;      // Terminator enables
   reg  [5:0]    pol_r;       // Falling-edge selects
   reg  [2:0]    in_clk_r;    // Input pacing mode
   reg           in_start_r;  // Input waits for trigger
   reg  [2:0]    out_clk_r;   // Output pacing mode
   reg  [1:0]    out_start_r; // Output start mode
   reg  [LW-1:0] thresh_r;    // Almost-empty threshold
   reg           in_en_r;     // Input path enable
   reg           out_en_r;    // Output path enable
   reg  [1:0]    in_st_r;     // Input state
   reg  [1:0]    out_st_r;    // Output state
   reg           in_trig_r;   // Input trigger seen
   reg           out_trig_r;  // Output trigger seen
   reg           in_ack_r;    // Acknowledge, active high
   reg           out_req_r;   // Request, active high
   reg  [2:0]    burst_r;     // Words left after ack drop
   reg  [2:0]    sent_r;      // Sends at the last three edges
   reg  [DW-1:0] out_data_r;  // Word on the output pins
   reg  [15:0]   in_cnt_r;    // Words sampled
   reg  [15:0]   out_cnt_r;   // Words sent
   reg  [31:0]   din_p1_r;    // Data pipe, matches sync delay
   reg  [31:0]   din_p2_r;
   reg  [31:0]   din_p3_r;
   reg  [31:0]   rd_nxt;      // Read mux
   reg           hit;         // Address decodes

   wire in_req_lvl;
   wire in_req_rise;
   wire in_trig_lvl;
   wire in_trig_rise;
   wire out_ack_lvl;
   wire out_trig_lvl;
   wire out_trig_rise;
   wire in_tick;
   wire out_tick;

   // Mask a half-word to 8 bits when narrow
   function [15:0] lane;
      input [15:0] d;
      input        narrow;
      begin
         lane = narrow ? {8'h00, d[7:0]} : d;
      end
   endfunction

   // Burst output modes
   function is_burst;
      input [2:0] m;
      begin
         is_burst = (m == `OUT_BURST_CNT) || (m == `OUT_BURST_SLOW) ||
                    (m == `OUT_BURST_FAST);
      end
   endfunction

   // Control pin synchronisers, polarity applied before edges
   pin_sync u_in_req (
      .pclk    (pclk),
      .presetn (presetn),
      .pin     (in_request_line),
      .invert  (pol_r[`POL_IN_REQ]),
      .level   (in_req_lvl),
      .rise    (in_req_rise)
   );
   pin_sync u_in_trig (
      .pclk    (pclk),
      .presetn (presetn),
      .pin     (in_trigger_line),
      .invert  (pol_r[`POL_IN_TRIG]),
      .level   (in_trig_lvl),
      .rise    (in_trig_rise)
   );
   pin_sync u_out_ack (
      .pclk    (pclk),
      .presetn (presetn),
      .pin     (out_acknowledge_line),
      .invert  (pol_r[`POL_OUT_ACK]),
      .level   (out_ack_lvl),
      .rise    ()
   );
   pin_sync u_out_trig (
      .pclk    (pclk),
      .presetn (presetn),
      .pin     (out_trigger_line),
      .invert  (pol_r[`POL_OUT_TRIG]),
      .level   (out_trig_lvl),
      .rise    (out_trig_rise)
   );

   // Input pace: counter 0, every clock or half rate
   pace_select u_in_pace (
      .pclk         (pclk),
      .presetn      (presetn),
      .src          (in_clk_r[1:0]),
      .counter_tick (counter0_tick),
      .tick         (in_tick)
   );

   // Output pace; burst modes map onto the same sources
   pace_select u_out_pace (
      .pclk         (pclk),
      .presetn      (presetn),
      .src          ((out_clk_r == `OUT_BURST_SLOW) ? `SRC_SLOW :
                     (out_clk_r == `OUT_BURST_FAST) ? `SRC_FAST :
                     (out_clk_r == `OUT_BURST_CNT)  ? `SRC_CNT  :
                     out_clk_r[1:0]),
      .counter_tick (counter1_tick),
      .tick         (out_tick)
   );

   // Port direction, width and terminators
   wire narrow_in  = (cfg_r == `CFG_NN) || (cfg_r == `CFG_NW);
   wire narrow_out = (cfg_r == `CFG_NN) || (cfg_r == `CFG_WN);
   wire wide_in    = (cfg_r == `CFG_WIDE_IN);
   wire wide_out   = (cfg_r == `CFG_WIDE_OUT);
   assign first_port_oe   = wide_out;
   assign second_port_oe  = ~wide_in;
   assign first_port_out  = wide_out ? out_data_r[31:16] : 16'h0000;
   assign second_port_out = lane(out_data_r[15:0], narrow_out);
   assign first_term_en   = term_r[0];
   assign second_term_en  = term_r[1];

   // Incoming word assembled from the delayed pins
   wire [31:0] in_asm = wide_in ? din_p3_r :
                        {16'h0000, lane(din_p3_r[15:0], narrow_in)};

   // Output level above threshold
   wire not_ae = (out_fifo_level > thresh_r);

   // Control line outputs with their polarity
   assign in_acknowledge_line = in_ack_r ^ pol_r[`POL_IN_ACK];
   assign out_request_line    = out_req_r ^ pol_r[`POL_OUT_REQ];

   // Input sample decision
   reg in_take;
   always @* begin
      in_take = 1'b0;
      if (in_st_r == ST_RUN) begin
         case (in_clk_r)
            `IN_PACE_STROBE: in_take = in_req_rise;
            `IN_PACE_HS:     in_take = ~in_ack_r & in_req_lvl &
                                       ~in_fifo_almost_full;
            default:         in_take = in_tick;
         endcase
      end
   end

   // Output send decision
   reg out_send;
   always @* begin
      out_send = 1'b0;
      if (out_st_r == ST_RUN && out_word_avail) begin
         if (out_clk_r == `OUT_PACE_HS) begin
            out_send = ~out_ack_lvl;
         end else if (is_burst(out_clk_r)) begin
            out_send = out_tick & (out_ack_lvl | (burst_r != 3'h0));
         end else begin
            out_send = out_tick;
         end
      end
   end
   assign out_word_take = out_send;

   // Words sent while a dropped ack was still in the synchroniser
   wire [2:0] in_flight = {2'h0, sent_r[0]} + {2'h0, sent_r[1]} +
                          {2'h0, sent_r[2]} + {2'h0, out_send};

   // Input direction state machine
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         in_st_r       <= ST_IDLE;
         in_trig_r     <= 1'b0;
         in_ack_r      <= 1'b0;
         in_word       <= {DW{1'b0}};
         in_word_valid <= 1'b0;
         in_cnt_r      <= 16'h0000;
         din_p1_r      <= 32'h0000_0000;
         din_p2_r      <= 32'h0000_0000;
         din_p3_r      <= 32'h0000_0000;
      end else begin
         din_p1_r      <= {second_port_in, first_port_in};
         din_p2_r      <= din_p1_r;
         din_p3_r      <= din_p2_r;
         in_word_valid <= in_take;
         if (in_take) begin
            in_word  <= in_asm;
            in_cnt_r <= in_cnt_r + 16'h0001;
         end
         case (in_st_r)
            ST_IDLE: begin
               in_ack_r  <= 1'b0;
               in_trig_r <= 1'b0;
               if (in_en_r) begin
                  in_st_r  <= ST_ARM;
                  in_cnt_r <= 16'h0000;
               end
            end
            ST_ARM: begin
               // Strobe mode acknowledges while armed too
               in_ack_r <= (in_clk_r == `IN_PACE_STROBE) & ~in_fifo_almost_full;
               if (in_trig_rise) begin
                  in_trig_r <= 1'b1;
               end
               if (!in_en_r) begin
                  in_st_r <= ST_IDLE;
               end else if (!in_start_r || in_trig_rise) begin
                  in_st_r <= ST_RUN;
               end
            end
            ST_RUN: begin
               if (!in_en_r) begin
                  in_st_r <= ST_IDLE;
               end else if (in_clk_r == `IN_PACE_STROBE) begin
                  in_ack_r <= ~in_fifo_almost_full;
               end else if (in_clk_r == `IN_PACE_HS) begin
                  // Ack after latching, held until request drops
                  if (in_take) begin
                     in_ack_r <= 1'b1;
                  end else if (!in_req_lvl) begin
                     in_ack_r <= 1'b0;
                  end
               end else begin
                  in_ack_r <= 1'b0;
               end
            end
            default: in_st_r <= ST_IDLE;
         endcase
      end
   end

   // Output direction state machine
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_st_r   <= ST_IDLE;
         out_trig_r <= 1'b0;
         out_req_r  <= 1'b0;
         burst_r    <= 3'h0;
         sent_r     <= 3'h0;
         out_data_r <= {DW{1'b0}};
         out_cnt_r  <= 16'h0000;
      end else begin
         if (out_send) begin
            out_data_r <= out_word;
            out_cnt_r  <= out_cnt_r + 16'h0001;
         end
         sent_r <= {sent_r[1:0], out_send};
         // Allowance reloads while ack is active, less words in flight
         if (out_ack_lvl) begin
            burst_r <= `BURST_EXTRA - in_flight;
         end else if (out_send && is_burst(out_clk_r) && burst_r != 3'h0) begin
            burst_r <= burst_r - 3'h1;
         end
         case (out_st_r)
            ST_IDLE: begin
               out_req_r  <= 1'b0;
               out_trig_r <= 1'b0;
               burst_r    <= 3'h0;
               if (out_en_r) begin
                  out_st_r  <= ST_ARM;
                  out_cnt_r <= 16'h0000;
               end
            end
            ST_ARM: begin
               if (out_trig_rise) begin
                  out_trig_r <= 1'b1;
               end
               if (!out_en_r) begin
                  out_st_r <= ST_IDLE;
               end else begin
                  case (out_start_r)
                     `OUT_START_NOW:  out_st_r <= ST_RUN;
                     `OUT_START_TRIG: if (out_trig_r || out_trig_rise)
                                         out_st_r <= ST_RUN;
                     `OUT_START_FIFO: if (not_ae)
                                         out_st_r <= ST_RUN;
                     default:         if ((out_trig_r || out_trig_rise) && not_ae)
                                         out_st_r <= ST_RUN;
                  endcase
               end
            end
            ST_RUN: begin
               if (!out_en_r) begin
                  out_st_r  <= ST_IDLE;
                  out_req_r <= 1'b0;
               end else if (out_clk_r == `OUT_PACE_HS) begin
                  if (out_send) begin
                     out_req_r <= 1'b1;
                     out_st_r  <= ST_WACK;
                  end
               end else begin
                  out_req_r <= out_send; // One-clock strobe per word
               end
            end
            ST_WACK: begin
               // Hold request until the receiver acknowledges
               if (out_ack_lvl || !out_en_r) begin
                  out_req_r <= 1'b0;
                  out_st_r  <= out_en_r ? ST_RUN : ST_IDLE;
               end
            end
            default: out_st_r <= ST_IDLE;
         endcase
      end
   end

   // APB: zero wait states, error on unmapped address
   wire wr_acc = psel & penable & pwrite;
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~hit;

   // Read mux and decode
   always @* begin
      hit    = 1'b1;
      rd_nxt = 32'h0000_0000;
      case (paddr)
         `REG_CONFIG:    rd_nxt = {26'h0, term_r, 1'b0, cfg_r};
         `REG_POLARITY:  rd_nxt = {26'h0, pol_r};
         `REG_IN_MODE:   rd_nxt = {27'h0, in_start_r, 1'b0, in_clk_r};
         `REG_OUT_MODE:  rd_nxt = {26'h0, out_start_r, 1'b0, out_clk_r};
         `REG_THRESH:    rd_nxt = {{(32-LW){1'b0}}, thresh_r};
         `REG_CONTROL:   rd_nxt = {30'h0, out_en_r, in_en_r};
         `REG_STATUS:    rd_nxt = {17'h0, burst_r, in_ack_r, out_req_r,
                                   out_trig_r, in_trig_r, not_ae, 1'b0,
                                   out_st_r, 2'h0, in_st_r};
         `REG_IN_COUNT:  rd_nxt = {16'h0, in_cnt_r};
         `REG_OUT_COUNT: rd_nxt = {16'h0, out_cnt_r};
         default:        hit = 1'b0;
      endcase
   end

   // Register writes in the access phase, read data caught in setup
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata      <= 32'h0000_0000;
         cfg_r       <= `CFG_RESET;
         term_r      <= 2'h0;
         pol_r       <= 6'h00;
         in_clk_r    <= `IN_PACE_CNT;
         in_start_r  <= 1'b0;
         out_clk_r   <= `OUT_PACE_CNT;
         out_start_r <= `OUT_START_NOW;
         thresh_r    <= `THRESH_RESET;
         in_en_r     <= 1'b0;
         out_en_r    <= 1'b0;
      end else begin
         if (psel && !penable) begin
            prdata <= pwrite ? 32'h0000_0000 : rd_nxt;
         end
         if (wr_acc) begin
            case (paddr)
               `REG_CONFIG: begin
                  if (pwdata[2:0] <= `CFG_WW) begin
                     cfg_r <= pwdata[2:0];
                  end
                  term_r <= pwdata[5:4];
               end
               `REG_POLARITY: pol_r <= pwdata[5:0];
               `REG_IN_MODE: begin
                  if (pwdata[2:0] <= `IN_PACE_HS) begin
                     in_clk_r <= pwdata[2:0];
                  end
                  in_start_r <= pwdata[4];
               end
               `REG_OUT_MODE: begin
                  if (pwdata[2:0] <= `OUT_BURST_FAST) begin
                     out_clk_r <= pwdata[2:0];
                  end
                  out_start_r <= pwdata[5:4];
               end
               `REG_THRESH:  thresh_r <= pwdata[LW-1:0];
               `REG_CONTROL: begin
                  in_en_r  <= pwdata[0];
                  out_en_r <= pwdata[1];
               end
               default: ;
            endcase
         end
      end
   end
endmodule // pio_mode_ctrl

// ---- pio_checker_assertions.sv ----
// Port-level checker of the parallel pattern I/O mode control
`timescale 1ns/1ns
module pio_checker #(
   parameter DW = 32
) (
   input wire          pclk,
   input wire          presetn,
   input wire          psel,
   input wire          penable,
   input wire          pready,
   input wire          pslverr,
   input wire          first_port_oe,
   input wire          second_port_oe,
   input wire [15:0]   first_port_out,
   input wire [15:0]   second_port_out,
   input wire [DW-1:0] out_word,
   input wire          out_word_avail,
   input wire          out_word_take
);
   // One clock domain for every check
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_ready; pready; endproperty
   a_ready: assert property (p_ready) else $error("bus slave stalled");
   property p_err; pslverr |-> psel && penable; endproperty
   a_err: assert property (p_err) else $error("error outside access phase");
   property p_oe; first_port_oe |-> second_port_oe; endproperty
   a_oe: assert property (p_oe) else $error("wide output with one port");
   property p_take; out_word_take |-> out_word_avail; endproperty
   a_take: assert property (p_take) else $error("word taken from empty source");
   property p_lo;
      out_word_take && second_port_oe |=> second_port_out[7:0] == $past(out_word[7:0]);
   endproperty
   a_lo: assert property (p_lo) else $error("low byte not presented");
   property p_hi;
      out_word_take && first_port_oe |=> first_port_out == $past(out_word[31:16]);
   endproperty
   a_hi: assert property (p_hi) else $error("upper half not on first port");
   property p_zero; !first_port_oe |-> first_port_out == 16'h0000; endproperty
   a_zero: assert property (p_zero) else $error("first port driven data");
   property p_hold; !out_word_take |=> $stable(second_port_out[7:0]); endproperty
   a_hold: assert property (p_hold) else $error("data moved without take");
endmodule // pio_checker
bind pio_mode_ctrl pio_checker #(.DW(DW)) u_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
   .pslverr(pslverr), .first_port_oe(first_port_oe), .second_port_oe(second_port_oe),
   .first_port_out(first_port_out), .second_port_out(second_port_out),
   .out_word(out_word), .out_word_avail(out_word_avail), .out_word_take(out_word_take));

// ---- periph_model.sv ----
// Far-side peripheral: strobed input words and output acknowledge
`timescale 1ns/1ns
module periph_model (
   input  wire        go,
   input  wire        slow,
   input  wire [31:0] base,
   input  wire        out_req,
   output reg         in_req,
   output reg         out_ack,
   output reg  [15:0] pa,
   output reg  [15:0] pb
);
   integer n;
   // Idle lines
   initial begin
      in_req = 1'b0;
      out_ack = 1'b0;
      pa = 16'h0000;
      pb = 16'h0000;
   end
   // Four words, one strobe each, 400 ns apart
   always @(posedge go) begin
      for (n = 0; n < 4; n = n + 1) begin
         pa <= base[15:0] + n[15:0];
         pb <= base[31:16];
         #100 in_req <= 1'b1;
         #200 in_req <= 1'b0;
         #100;
      end
      pa <= ~pa; // Released lines carry no stale word
      pb <= ~pb;
   end
   // Acknowledge follows request, prompt or slow
   always @(posedge out_req) out_ack <= #(slow ? 900 : 150) 1'b1;
   always @(negedge out_req) out_ack <= #(slow ? 900 : 150) 1'b0;
endmodule // periph_model

// ---- tb_top.sv ----
// Self-checking bench of the parallel pattern I/O mode control
`timescale 1ns/1ns
`include "pio_map.vh"
module tb_top;
   reg         pclk, presetn, psel, penable, pwrite, avail, afull, go, slow, e, trig;
   reg  [7:0]  paddr;
   reg  [31:0] pwdata, out_word, r;
   reg  [15:0] level;
   reg  [71:0] row [0:4];
   wire [31:0] prdata, in_word;
   wire [15:0] pa, pb, fpo, spo;
   wire        pready, pslverr, foe, soe, fte, ste, ireq, iack, oreq, oack, ivld, take;
   integer     failures, compares, takes, i, k;
   pio_mode_ctrl uut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .first_port_in(pa), .first_port_out(fpo), .first_port_oe(foe),
      .second_port_in(pb), .second_port_out(spo), .second_port_oe(soe),
      .first_term_en(fte), .second_term_en(ste), .in_request_line(ireq),
      .in_acknowledge_line(iack), .in_trigger_line(1'b0), .out_request_line(oreq),
      .out_acknowledge_line(oack), .out_trigger_line(trig), .counter0_tick(1'b0),
      .counter1_tick(1'b0), .in_word(in_word), .in_word_valid(ivld),
      .in_fifo_almost_full(afull), .out_word(out_word), .out_word_avail(avail),
      .out_fifo_level(level), .out_word_take(take));
   periph_model peer (.go(go), .slow(slow), .base(32'hC35A0F00), .out_req(oreq),
      .in_req(ireq), .out_ack(oack), .pa(pa), .pb(pb));
   // Clock, 50 ns period
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   // Output source pops on each take
   always @(posedge pclk) if (take === 1'b1) begin
      out_word <= out_word + 32'h00010001;
      takes <= takes + 1;
   end
   task chk(input [31:0] g, x);
      compares = compares + 1;
      if (g !== x) begin
         failures = failures + 1;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask
   // One bus transfer, held until pready
   task apb(input w, input [7:0] a, input [31:0] d);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task wrchk(input [7:0] a, input [31:0] d, x);
      apb(1'b1, a, d);
      apb(1'b0, a, 32'h0);
      chk(r, x);
   endtask
   task close_out;
      $display("compares=%0d failures=%0d", compares, failures);
      if (failures == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Watchdog
   initial begin
      #(50 * 20000);
      failures = failures + 1;
      close_out;
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = 0;
      {avail, afull, go, slow, trig, level, failures, compares, takes} = 0;
      out_word = 32'h1234ABCD;
      row = '{{`REG_CONFIG, 32'h32, 32'h32}, {`REG_CONFIG, 32'h07, 32'h02},
         {`REG_POLARITY, 32'h3F, 32'h3F}, {`REG_THRESH, 32'h1234, 32'h1234},
         {`REG_POLARITY, 32'h0, 32'h0}};
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `REG_CONFIG, 0);
      chk(r, `CFG_RESET);
      apb(1'b0, `REG_THRESH, 0);
      chk(r, `THRESH_RESET);
      chk({foe, soe}, 2'b01);
      for (i = 0; i < 5; i++) wrchk(row[i][71:64], row[i][63:32], row[i][31:0]);
      // Codes 0 to 6, out-of-range ones ignored
      for (k = 0; k < 7; k++) begin
         wrchk(`REG_CONFIG, k, k < 6 ? k : 5);
         wrchk(`REG_IN_MODE, k, k < 5 ? k : 4);
         wrchk(`REG_OUT_MODE, k, k);
      end
      apb(1'b0, 8'h40, 0);
      chk(e, 1'b1);
      chk(r, 32'h0);
      $display("test registers done");
      // Wide input sampled on strobes
      wrchk(`REG_CONFIG, 32'h10, 32'h10);
      chk({fte, ste}, 2'b10);
      apb(1'b1, `REG_IN_MODE, `IN_PACE_STROBE);
      apb(1'b1, `REG_CONTROL, 32'h1);
      go <= 1'b1;
      repeat (4) @(negedge pclk);
      chk(iack, 1'b1);
      for (k = 0; k < 4; k++) begin
         for (i = 0; i < 40 && ivld !== 1'b1; i++) @(negedge pclk);
         chk(in_word, {16'hC35A, 16'h0F00 + k[15:0]});
         @(negedge pclk);
      end
      @(posedge pclk);
      afull <= 1'b1;
      repeat (4) @(negedge pclk);
      chk(iack, 1'b0);
      $display("test strobe input done");
      // Wide output, request/acknowledge
      apb(1'b1, `REG_CONTROL, 0);
      afull <= 1'b0;
      apb(1'b1, `REG_CONFIG, `CFG_WIDE_OUT);
      apb(1'b1, `REG_OUT_MODE, `OUT_PACE_HS);
      avail <= 1'b1;
      apb(1'b1, `REG_CONTROL, 32'h2);
      for (k = 0; k < 3; k++) begin
         slow = (k == 2);
         for (i = 0; i < 60 && oreq !== 1'b1; i++) @(negedge pclk);
         chk({fpo, spo}, out_word - 32'h00010001);
         chk(takes, k + 1);
         for (i = 0; i < 60 && oreq !== 1'b0; i++) @(negedge pclk);
      end
      $display("test output handshake done");
      // Start held while source is almost empty
      apb(1'b1, `REG_CONTROL, 0);
      apb(1'b1, `REG_THRESH, 32'h10);
      level <= 16'h0010;
      apb(1'b1, `REG_OUT_MODE, 32'h21);
      k = takes;
      apb(1'b1, `REG_CONTROL, 32'h2);
      repeat (30) @(negedge pclk);
      chk(takes, k);
      @(posedge pclk);
      level <= 16'h0011;
      for (i = 0; i < 20 && takes == k; i++) @(negedge pclk);
      chk(takes != k, 1);
      $display("test fifo start done");
      // Start held until the trigger line rises
      apb(1'b1, `REG_CONTROL, 0);
      apb(1'b1, `REG_OUT_MODE, 32'h11);
      k = takes;
      apb(1'b1, `REG_CONTROL, 32'h2);
      repeat (20) @(negedge pclk);
      chk(takes, k);
      trig = 1'b1;
      for (i = 0; i < 20 && takes == k; i++) @(negedge pclk);
      chk(takes != k, 1);
      $display("test trigger start done");
      close_out;
   end
endmodule // tb_top
